/* hdl/sls_top.sv */
// Speed limit selection for torque-controlled operation, APB slave
`timescale 1ns/1ns
`default_nettype none
module sls_top #(
	parameter int unsigned NUM_ENTRIES = sls_pkg::ENTRY_CNT // Entries
) (
	input  wire logic               clk_sys,                   // Clock
	input  wire logic               rst,                       // Reset
	input  wire logic [11:0]        paddr,                     // APB addr
	input  wire logic               psel,                      // APB sel
	input  wire logic               penable,                   // APB en
	input  wire logic               pwrite,                    // APB dir
	input  wire logic [31:0]        pwdata,                    // APB wdata
	input  wire logic [3:0]         pstrb,                     // APB strb
	output logic [31:0]             prdata,                    // APB rdata
	output logic                    pready,                    // APB ready
	output logic                    pslverr,                   // APB error
	input  wire logic               entry_select0,             // Pin
	input  wire logic               entry_select1,             // Pin
	input  wire logic               entry_select2,             // Pin
	input  wire logic [15:0]        internal_speed_pot,        // r/min
	input  wire logic signed [15:0] ext_analog_mv,             // mV
	input  wire logic [15:0]        motor_rpm,                 // Speed
	input  wire logic               sys_analog_en_nv,          // Stored
	output logic                    analog_en_pending,         // To store
	output logic                    analog_en_active,          // In use
	output logic [15:0]             speed_limit_rpm,           // Limit
	output logic [15:0]             torque_cmd,                // Torque
	output logic                    speed_limiting_indication  // Limiting
);

	typedef struct packed {
		logic [2:0]                   sel_s1;
		logic [2:0]                   sel_s2;
		logic [2:0]                   sel_s3;
		logic [2:0]                   sel;
		logic [NUM_ENTRIES-1:0][31:0] entry;
		logic                         auto_off;
		logic                         an_pend;
		logic                         an_eff;
		logic [15:0]                  gain;
		logic signed [15:0]           offset;
		logic signed [15:0]           capt;
		logic [31:0]                  prdata;
		logic [15:0]                  limit;
		logic [15:0]                  torque;
		logic                         limiting;
	} sls_state_t;

	sls_state_t s_q;
	sls_state_t s_d;

	sls_scale_if sc ();

	// Clamp a speed into the legal range
	function automatic logic [15:0] clamp_speed(input logic [15:0] v);
		if (v > sls_pkg::SPEED_MAX_RPM) begin
			return sls_pkg::SPEED_MAX_RPM;
		end
		return v;
	endfunction

	// Clamp an offset voltage into its legal range
	function automatic logic signed [15:0] clamp_offset(
		input logic signed [15:0] v);
		if (v > sls_pkg::OFFSET_MAX_MV) begin
			return sls_pkg::OFFSET_MAX_MV;
		end
		if (v < sls_pkg::OFFSET_MIN_MV) begin
			return sls_pkg::OFFSET_MIN_MV;
		end
		return v;
	endfunction

	// Byte-lane merge of write data into an old word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (wd & m);
	endfunction

	// Entry window decode
	function automatic logic is_entry(input logic [11:0] a);
		return a[11:5] == sls_pkg::ADDR_ENTRY_BASE[11:5] &&
			32'(a[4:2]) < NUM_ENTRIES;
	endfunction

	// Whole-map decode, misaligned addresses are unmapped
	function automatic logic addr_ok(input logic [11:0] a);
		if (a[1:0] != 2'h0) begin
			return 1'b0;
		end
		return a == sls_pkg::ADDR_CTRL || a == sls_pkg::ADDR_GAIN ||
			a == sls_pkg::ADDR_OFFSET || a == sls_pkg::ADDR_STATUS ||
			a == sls_pkg::ADDR_CAPT || is_entry(a);
	endfunction

	// Read mux, unmapped reads return zero
	function automatic logic [31:0] rd_word(input logic [11:0] a,
		input sls_state_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (!addr_ok(a)) begin
			w = 32'h0000_0000;
		end else if (is_entry(a)) begin
			w = s.entry[a[4:2]];
		end else if (a == sls_pkg::ADDR_CTRL) begin
			w[sls_pkg::CTRL_AUTO_BIT]   = s.auto_off;
			w[sls_pkg::CTRL_ANALOG_BIT] = s.an_pend;
		end else if (a == sls_pkg::ADDR_GAIN) begin
			w = {16'h0000, s.gain};
		end else if (a == sls_pkg::ADDR_OFFSET) begin
			w = 32'(s.offset);
		end else if (a == sls_pkg::ADDR_CAPT) begin
			w = 32'(s.capt);
		end else begin
			w[sls_pkg::STAT_EFF_BIT]                     = s.an_eff;
			w[sls_pkg::STAT_LIM_BIT]                     = s.limiting;
			w[sls_pkg::STAT_IDX_LSB +: 3]                = s.sel;
			w[sls_pkg::STAT_LIMT_LSB +: 16]              = s.limit;
		end
		return w;
	endfunction

	// Zero-wait slave: data is staged in setup, so ready can stay high
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_ok(paddr);
	assign prdata  = s_q.prdata;

	// Scaler inputs, the offset source depends on auto mode
	assign sc.volt_mv   = ext_analog_mv;
	assign sc.offset_mv = s_q.auto_off ? s_q.capt : s_q.offset;
	assign sc.gain      = s_q.gain;

	sls_scale u_scale (
		.sc (sc)
	);

	// Registered outputs
	assign analog_en_pending         = s_q.an_pend;
	assign analog_en_active          = s_q.an_eff;
	assign speed_limit_rpm           = s_q.limit;
	assign torque_cmd                = s_q.torque;
	assign speed_limiting_indication = s_q.limiting;

	// Next-state logic for the whole block
	always_comb begin
		logic        wr_acc;
		logic [31:0] wm;
		logic [15:0] lim;
		logic [15:0] trq;
		wr_acc = psel && penable && pwrite && addr_ok(paddr);
		wm     = 32'h0000_0000;
		lim    = 16'h0000;
		trq    = 16'h0000;
		s_d    = s_q;

		// Selects come from pins: three flops, accept when last two agree
		s_d.sel_s1 = {entry_select2, entry_select1, entry_select0};
		s_d.sel_s2 = s_q.sel_s1;
		s_d.sel_s3 = s_q.sel_s2;
		if (s_q.sel_s2 == s_q.sel_s3) begin
			s_d.sel = s_q.sel_s3;
		end

		// Read data staged during the setup cycle
		if (psel && !penable && !pwrite) begin
			s_d.prdata = rd_word(paddr, s_q);
		end

		// Register writes take effect in the access cycle
		if (wr_acc) begin
			if (is_entry(paddr)) begin
				wm = merge(s_q.entry[paddr[4:2]], pwdata, pstrb);
				wm[sls_pkg::ENT_SPEED_LSB +: 16] =
					clamp_speed(wm[sls_pkg::ENT_SPEED_LSB +: 16]);
				s_d.entry[paddr[4:2]] = wm;
			end else if (paddr == sls_pkg::ADDR_CTRL) begin
				wm = merge({29'h0, s_q.an_pend, 1'b0, s_q.auto_off},
					pwdata, pstrb);
				s_d.auto_off = wm[sls_pkg::CTRL_AUTO_BIT];
				// Only stored here; the active copy waits for reset
				s_d.an_pend = wm[sls_pkg::CTRL_ANALOG_BIT];
				if (wm[sls_pkg::CTRL_APPLY_BIT] &&
					wm[sls_pkg::CTRL_AUTO_BIT]) begin
					s_d.capt = ext_analog_mv;
				end
			end else if (paddr == sls_pkg::ADDR_GAIN) begin
				wm = merge({16'h0000, s_q.gain}, pwdata, pstrb);
				s_d.gain = clamp_speed(wm[15:0]);
			end else if (paddr == sls_pkg::ADDR_OFFSET) begin
				wm = merge(32'(s_q.offset), pwdata, pstrb);
				s_d.offset = clamp_offset(wm[15:0]);
			end
		end

		// Source of the active limit depends on the latched setting
		if (s_q.an_eff && s_q.sel == sls_pkg::POT_ENTRY) begin
			lim = clamp_speed(internal_speed_pot);
		end else if (s_q.an_eff && s_q.sel == sls_pkg::EXT_ENTRY) begin
			lim = sc.limit_rpm;
		end else begin
			lim = s_q.entry[s_q.sel][sls_pkg::ENT_SPEED_LSB +: 16];
		end
		trq = s_q.entry[s_q.sel][sls_pkg::ENT_TORQUE_LSB +: 16];
		s_d.limit    = lim;
		s_d.limiting = motor_rpm >= lim;
		// Torque is withheld at the limit; a crude but safe governor
		s_d.torque = (motor_rpm >= lim) ? 16'h0000 : trq;

		// Reset acts as power cycle: the stored setting becomes active
		if (rst) begin
			s_d          = '0;
			s_d.entry    = {NUM_ENTRIES{sls_pkg::ENTRY_RST}};
			s_d.auto_off = sls_pkg::AUTO_RST;
			s_d.gain     = sls_pkg::GAIN_RST;
			s_d.offset   = sls_pkg::OFFSET_RST;
			s_d.an_pend  = sys_analog_en_nv;
			s_d.an_eff   = sys_analog_en_nv;
		end
	end

	// State register
	always_ff @(posedge clk_sys) begin
		s_q <= s_d;
	end

endmodule // sls_top
`default_nettype wire

/* hdl/sls_pkg.sv */
// Shared constants for the speed limit selection block
package sls_pkg;

	// Register byte addresses
	localparam logic [11:0] ADDR_CTRL       = 12'h000;
	localparam logic [11:0] ADDR_GAIN       = 12'h004;
	localparam logic [11:0] ADDR_OFFSET     = 12'h008;
	localparam logic [11:0] ADDR_STATUS     = 12'h00c;
	localparam logic [11:0] ADDR_CAPT       = 12'h010;
	localparam logic [11:0] ADDR_ENTRY_BASE = 12'h020;

	// Control register fields
	localparam int unsigned CTRL_AUTO_BIT   = 0;
	localparam int unsigned CTRL_APPLY_BIT  = 1;
	localparam int unsigned CTRL_ANALOG_BIT = 2;

	// Status register fields
	localparam int unsigned STAT_EFF_BIT  = 0;
	localparam int unsigned STAT_LIM_BIT  = 1;
	localparam int unsigned STAT_IDX_LSB  = 4;
	localparam int unsigned STAT_LIMT_LSB = 16;

	// Entry word fields
	localparam int unsigned ENT_SPEED_LSB  = 0;
	localparam int unsigned ENT_TORQUE_LSB = 16;

	// Number of operation-data entries and the analog slots
	localparam int unsigned ENTRY_CNT = 8;
	localparam logic [2:0]  POT_ENTRY = 3'h0;
	localparam logic [2:0]  EXT_ENTRY = 3'h1;

	// Limits and scaling, speeds in r/min, voltages in mV
	localparam logic [15:0]        SPEED_MAX_RPM = 16'h157c;
	localparam logic [15:0]        MV_PER_V      = 16'h03e8;
	localparam logic signed [15:0] OFFSET_MAX_MV = 16'sh03e8;
	localparam logic signed [15:0] OFFSET_MIN_MV = -16'sh03e8;

	// Reset values
	localparam logic [15:0]        GAIN_RST   = 16'h0226;
	localparam logic signed [15:0] OFFSET_RST = 16'sh0000;
	localparam logic               AUTO_RST   = 1'h0;
	localparam logic [31:0]        ENTRY_RST  = 32'h0000_0000;

endpackage

/* hdl/sls_scale_if.sv */
// Carrier between the selector and the analog speed scaler
`timescale 1ns/1ns
`default_nettype none
interface sls_scale_if;
	logic signed [15:0] volt_mv;   // External analog input, mV
	logic signed [15:0] offset_mv; // Zero-speed reference, mV
	logic [15:0]        gain;      // r/min per volt
	logic [15:0]        limit_rpm; // Scaled and clamped limit

	modport src  (output volt_mv, output offset_mv, output gain,
	              input limit_rpm);
	modport calc (input volt_mv, input offset_mv, input gain,
	              output limit_rpm);
endinterface
`default_nettype wire

/* hdl/sls_scale.sv */
// Converts the external analog voltage into a speed limit
`timescale 1ns/1ns
`default_nettype none
module sls_scale (
	sls_scale_if.calc sc // Voltage, offset and gain in, limit out
);
	logic signed [16:0] diff;
	logic [32:0]        prod;
	logic [32:0]        quo;

	// Offset first, then gain, then clamp into the legal range
	always_comb begin
		diff = 17'(sc.volt_mv) - 17'(sc.offset_mv);
		prod = 33'h0;
		quo  = 33'h0;
		if (diff[16] || diff == 17'sh00000) begin
			sc.limit_rpm = 16'h0000;
		end else begin
			prod = 33'(diff[15:0]) * 33'(sc.gain);
			quo  = prod / 33'(sls_pkg::MV_PER_V);
			if (quo > 33'(sls_pkg::SPEED_MAX_RPM)) begin
				sc.limit_rpm = sls_pkg::SPEED_MAX_RPM;
			end else begin
				sc.limit_rpm = quo[15:0];
			end
		end
	end
endmodule // sls_scale
`default_nettype wire

/* bench/sls_top_sva.sv */
// Port checker for the speed limit selection block
`timescale 1ns/1ns
`default_nettype none
module sls_top_sva (
	input wire logic        clk_sys,                  // Clock
	input wire logic        rst,                      // Reset
	input wire logic        psel,                     // APB sel
	input wire logic        penable,                  // APB en
	input wire logic        pready,                   // APB ready
	input wire logic        pslverr,                  // APB error
	input wire logic        entry_select0,            // Pin
	input wire logic        entry_select1,            // Pin
	input wire logic        entry_select2,            // Pin
	input wire logic [15:0] internal_speed_pot,       // Pot
	input wire logic [15:0] motor_rpm,                // Speed
	input wire logic        sys_analog_en_nv,         // Stored
	input wire logic        analog_en_active,         // In use
	input wire logic [15:0] speed_limit_rpm,          // Limit
	input wire logic [15:0] torque_cmd,               // Torque
	input wire logic        speed_limiting_indication // Limiting
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [2:0] up_q;
	wire logic [2:0] pins = {entry_select2, entry_select1, entry_select0};
	// Cycles since reset, so $past in the checks gated on it never looks into the reset
	always_ff @(posedge clk_sys)
		if (rst) up_q <= 3'h0;
		else if (up_q != 3'h7) up_q <= up_q + 3'h1;
	property p_rdy; pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready low");
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("pslverr outside access");
	property p_max; speed_limit_rpm <= sls_pkg::SPEED_MAX_RPM; endproperty
	a_max: assert property (p_max) else $error("limit over max");
	property p_hold; up_q != 3'h0 |-> $stable(analog_en_active); endproperty
	a_hold: assert property (p_hold) else $error("setting moved");
	property p_load;
		$fell(rst) |-> analog_en_active == $past(sys_analog_en_nv);
	endproperty
	a_load: assert property (p_load) else $error("setting not loaded");
	property p_ind; (up_q == 3'h7 && $stable(motor_rpm)
		&& $stable(speed_limit_rpm))[*2] |->
		speed_limiting_indication == (motor_rpm >= speed_limit_rpm);
	endproperty
	a_ind: assert property (p_ind) else $error("indication wrong");
	property p_trq; (up_q == 3'h7 && $stable(motor_rpm) && $stable(
		speed_limit_rpm) && motor_rpm >= speed_limit_rpm)[*2] |->
		torque_cmd == 16'h0000;
	endproperty
	a_trq: assert property (p_trq) else $error("torque over limit");
	property p_pot; (up_q == 3'h7 && analog_en_active && pins == 3'h0
		&& $stable(internal_speed_pot))[*8] |-> speed_limit_rpm ==
		(internal_speed_pot > sls_pkg::SPEED_MAX_RPM ?
		sls_pkg::SPEED_MAX_RPM : internal_speed_pot);
	endproperty
	a_pot: assert property (p_pot) else $error("pot limit wrong");
endmodule // sls_top_sva
bind sls_top sls_top_sva sls_top_sva_inst (.clk_sys, .rst, .psel, .penable,
	.pready, .pslverr, .entry_select0, .entry_select1, .entry_select2,
	.internal_speed_pot, .motor_rpm, .sys_analog_en_nv, .analog_en_active,
	.speed_limit_rpm, .torque_cmd, .speed_limiting_indication);
`default_nettype wire

/* bench/sls_host.sv */
// Host controller model driving the entry select pins
`timescale 1ns/1ns
`default_nettype none
module sls_host (
	input  wire logic       clk_sys,       // Clock
	input  wire logic [2:0] idx,           // Entry wanted
	output logic            entry_select0, // Pin
	output logic            entry_select1, // Pin
	output logic            entry_select2  // Pin
);
	// Pins change just after an edge, as an output stage; one process
	// drives them, so they are unknown only until the first edge in reset
	always @(posedge clk_sys) begin
		{entry_select2, entry_select1, entry_select0} <= idx;
	end
endmodule // sls_host
`default_nettype wire

/* bench/sls_top_tb.sv */
// Self-checking bench for the speed limit selection block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module sls_top_tb;
	logic               clk_sys, rst, psel, penable, pwrite, nv, err;
	logic               pready, pslverr, e0, e1, e2, pend, act, ind;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, rd, d;
	logic [15:0]        pot, rpm, lim, trq, lf;
	logic signed [15:0] mv;
	logic [2:0]         idx;
	int                 fails, n_checks, spd[8], tq[8], gain, off, capt;
	int                 auto_en, act_m;
	sls_top sls_top_inst (.clk_sys, .rst, .paddr, .psel, .penable, .pwrite,
		.pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
		.entry_select0(e0), .entry_select1(e1), .entry_select2(e2),
		.internal_speed_pot(pot), .ext_analog_mv(mv), .motor_rpm(rpm),
		.sys_analog_en_nv(nv), .analog_en_pending(pend),
		.analog_en_active(act), .speed_limit_rpm(lim), .torque_cmd(trq),
		.speed_limiting_indication(ind));
	sls_host sls_host_inst (.clk_sys, .idx, .entry_select0(e0),
		.entry_select1(e1), .entry_select2(e2));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Expected limit of entry i, clamped like the pot range
	function automatic logic [15:0] exp_lim(input int i);
		int v;
		v = mv - (auto_en ? capt : off);
		if (act_m && i == 1) v = (v <= 0) ? 0 : gain * v / 1000;
		else if (act_m && i == 0) v = pot;
		else v = spd[i];
		return (v > 5500) ? sls_pkg::SPEED_MAX_RPM : 16'(v);
	endfunction
	// One APB transfer; the trailing edge lets outputs settle
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task do_rst;
		rst <= 1'b1;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
	endtask
	task chk_one(input int i);
		logic [15:0] e;
		lf = nxt(lf);
		idx <= 3'(i);
		rpm <= {3'h0, lf[12:0]};
		repeat (10) @(posedge clk_sys);
		e = exp_lim(i);
		`CHK(lim, e)
		`CHK(ind, rpm >= e)
		`CHK(trq, (rpm >= e) ? 16'h0000 : 16'(tq[i]))
		apb(1'b0, sls_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd[6:4], 3'(i))
		`CHK(rd[31:16], e)
		`CHK(rd[1], rpm >= e)
		`CHK(rd[0], 1'(act_m))
	endtask
	task results;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Hang guard, far beyond the few hundred cycles the run needs
	initial begin
		repeat (30000) @(posedge clk_sys);
		fails++;
		results;
	end
	initial begin
		{psel, penable, pwrite, nv, paddr, pwdata} = '0;
		rst = 1'b1;
		{pot, rpm, mv, idx} = '0;
		lf = 16'h0057;
		gain = 550;
		do_rst;
		apb(1'b0, sls_pkg::ADDR_GAIN, 32'h0);
		`CHK(rd, 32'h0000_0226)
		apb(1'b0, 12'h040, 32'h0);
		`CHK(err, 1'b1)
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, 12'h020 + 12'(4 * i), 32'h0);
			`CHK(rd, 32'h0)
			lf = nxt(lf);
			d = {lf, (i == 7) ? 16'hffff : nxt(lf)};
			apb(1'b1, 12'h020 + 12'(4 * i), d);
			spd[i] = (d[15:0] > 5500) ? 5500 : d[15:0];
			tq[i] = d[31:16];
			// Read back: the speed field comes back clamped
			apb(1'b0, 12'h020 + 12'(4 * i), 32'h0);
			`CHK(rd, {d[31:16], 16'(spd[i])})
		end
		for (int i = 0; i < 8; i++) chk_one(i);
		// A new setting waits for the next power cycle
		apb(1'b1, sls_pkg::ADDR_CTRL, 32'h4);
		`CHK(pend, 1'b1)
		`CHK(act, 1'b0)
		nv <= 1'b1;
		do_rst;
		act_m = 1;
		`CHK(act, 1'b1)
		`CHK(pend, 1'b1)
		for (int i = 0; i < 8; i++) {spd[i], tq[i]} = '0;
		pot <= 16'h1f40;
		mv <= 16'sh07d0;
		for (int i = 0; i < 8; i++) chk_one(i);
		apb(1'b1, sls_pkg::ADDR_OFFSET, 32'h3e8);
		off = 1000;
		pot <= 16'h04d2;
		mv <= 16'sh01f4;
		chk_one(0);
		chk_one(1);
		apb(1'b1, sls_pkg::ADDR_GAIN, 32'h157c);
		gain = 5500;
		mv <= 16'sh0bb8;
		chk_one(1);
		// Auto offset captures the present input as zero
		mv <= 16'sh00c8;
		apb(1'b1, sls_pkg::ADDR_CTRL, 32'h3);
		// Clearing the stored setting leaves the active one alone
		`CHK(pend, 1'b0)
		`CHK(act, 1'b1)
		{auto_en, capt} = {32'd1, 32'd200};
		apb(1'b0, sls_pkg::ADDR_CAPT, 32'h0);
		`CHK(rd, 32'h0000_00c8)
		mv <= 16'sh012c;
		chk_one(1);
		results;
	end
endmodule // sls_top_tb
`default_nettype wire
